// File: rtl/tiu_pkg.sv
// Shared constants and carriers for the trace and interrupt exception unit
package tiu_pkg;
   // Trace mode field: {high bit, low bit}
   localparam logic [1:0] TRACE_OFF  = 2'h0;
   localparam logic [1:0] TRACE_FLOW = 2'h1;
   localparam logic [1:0] TRACE_EACH = 2'h2;
   localparam logic [1:0] TRACE_RSVD = 2'h3;
   localparam logic [2:0] LEVEL_NONE = 3'h0;
   localparam logic [2:0] LEVEL_NMI  = 3'h7;
   localparam logic [3:0] IACK_SPACE_CODE = 4'hf;
   localparam logic [7:0] VEC_TRACE     = 8'h09;
   localparam logic [7:0] VEC_BKPT      = 8'h0c;
   localparam logic [7:0] VEC_SPURIOUS  = 8'h18;
   localparam logic [7:0] VEC_AUTO_BASE = 8'h18;

   typedef enum logic [1:0] {EK_TRACE, EK_IRQ, EK_BKPT} tiu_kind_t;

   // Exception request handed to the core's stacking sequencer
   typedef struct packed {
      logic       valid;
      tiu_kind_t  kind;
      logic [7:0] vector;
      logic [2:0] new_mask;
      logic       set_super;
      logic       clr_trace;
   } tiu_exc_t;

   // Completion report for one instruction
   typedef struct packed {
      logic done;
      logic nonseq;
      logic forced;
      logic halt;
      logic rte_fault;
   } tiu_insn_t;
endpackage

// File: rtl/tiu_unit.sv
// Trace and interrupt exception sequencing for the processor core
`timescale 1ns/1ps
// Behaviour
// - Two trace bits select off, flow, every
// - Flow mode traces only non-sequential PC updates
// - Every-instruction mode traces each completed instruction
// - Skipped or refused instructions never trace
// - Aborted instruction traces only after restart completes
// - Trace exception precedes pending interrupt
// - Forced exception precedes its trace exception
// - Trace exception precedes pending breakpoint
// - Trace: supervisor, clear trace bits, trace vector
// - Traced halt in every-instruction mode resumes, never stops
// - Return from fault handler is never traced
// - Levels above mask taken; seven unmaskable
// - Request valid after two stable clock periods
// - Level-seven edge latched until acknowledged
// - Requests pend; checked at instruction boundaries
// - Accept: supervisor, no trace, mask to level
// - Acknowledge cycle in special space, level on address
// - Autovector built from level
// - Bus error on acknowledge gives spurious vector
// - Stack vector, next PC, status; load vector
// - Level seven on rise or mask drop
module tiu_unit
   import tiu_pkg::*;
(
   input  wire logic       CLOCK,          // 250 MHz core clock
   input  wire logic       RESET_N,        // Synchronous reset
   input  wire logic [7:1] IRQ_N,          // Interrupt request lines, pins
   input  wire logic [1:0] SR_TRACE,       // Status trace bits
   input  wire logic [2:0] SR_MASK,        // Status priority mask
   input  wire logic       INSN_START,     // Instruction begins
   input  wire tiu_insn_t  INSN,           // Instruction completion report
   input  wire logic       INSN_CANCEL,    // Instruction skipped or aborted
   input  wire logic       EXC_END,        // Core finished an exception
   input  wire logic       BKPT_PEND,      // Breakpoint pending
   input  wire logic       IACK_DONE,      // Acknowledge cycle ended
   input  wire logic       IACK_AUTOVEC,   // Responder asks autovector
   input  wire logic       IACK_BERR,      // Acknowledge ended by bus error
   input  wire logic [7:0] IACK_DATA,      // Vector from responder
   output tiu_exc_t        EXC,            // Exception request to core
   output logic            IACK_REQ,       // Run acknowledge cycle
   output logic [3:0]      IACK_SPACE,     // Address space code
   output logic [2:0]      IACK_ADDR,      // Acknowledged level
   output logic            PROCEED,        // Next instruction may start
   output logic            HALT_INHIBIT,   // Halt must not stop
   output logic            TRACE_PENDING,  // Trace owed
   output logic [2:0]      IPEND_LEVEL     // Pending interrupt level
);

   typedef enum logic [2:0] {ST_RUN, ST_FORCED, ST_CHECK, ST_EXC, ST_IACK} tiu_state_t;

   tiu_state_t state;
   tiu_state_t next_state;

   logic [7:1] irq_s1;
   logic [7:1] irq_s2;
   logic [7:1] irq_s3;
   logic [7:1] irq_filt;
   logic [2:0] prev_level;
   logic [2:0] prev_mask;
   logic       nmi_pend;
   logic [1:0] tr_mode;
   logic       trace_pend;
   logic [2:0] iack_lvl;

   function automatic logic [2:0] tiu_encode(input logic [7:1] req);
      logic [2:0] lvl;
      lvl = LEVEL_NONE;
      for (int i = 1; i <= 7; i++) begin
         if (req[i]) begin
            lvl = 3'(i);
         end
      end
      return lvl;
   endfunction

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         irq_s1   <= '1;
         irq_s2   <= '1;
         irq_s3   <= '1;
         irq_filt <= '1;
      end else begin
         irq_s1 <= IRQ_N;
         irq_s2 <= irq_s1;
         irq_s3 <= irq_s2;
         if (irq_s2 == irq_s3) begin
            irq_filt <= irq_s2;
         end
      end
   end

   wire [2:0] irq_level = tiu_encode(~irq_filt);
   wire       lvl7      = irq_level == LEVEL_NMI;

   // Rise to seven, or mask drop under held seven
   wire nmi_edge = lvl7 && (prev_level != LEVEL_NMI
                            || (prev_mask == LEVEL_NMI && SR_MASK != LEVEL_NMI));
   wire nmi_ack  = state == ST_IACK && IACK_DONE && iack_lvl == LEVEL_NMI;

   // Maskable levels must exceed the mask
   wire [2:0] mask_level = (!lvl7 && irq_level > SR_MASK) ? irq_level : LEVEL_NONE;
   wire [2:0] int_level  = nmi_pend ? LEVEL_NMI : mask_level;

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         prev_level <= LEVEL_NONE;
         prev_mask  <= LEVEL_NONE;
         nmi_pend   <= 1'b0;
      end else begin
         prev_level <= irq_level;
         prev_mask  <= SR_MASK;
         // Edge held until its acknowledge; set wins
         nmi_pend   <= nmi_edge || (nmi_pend && !nmi_ack);
      end
   end

   // Reserved encoding decodes as no tracing
   wire flow_mode = tr_mode == TRACE_FLOW;
   wire each_mode = tr_mode == TRACE_EACH;

   // Flow mode needs a non-sequential update
   // Return from a fault handler is exempt
   wire trace_hit = INSN.done && !INSN.rte_fault
                    && ((flow_mode && INSN.nonseq) || each_mode);
   wire trace_ack = state == ST_EXC && EXC_END && EXC.kind == EK_TRACE;
   wire insn_ok   = state == ST_RUN && INSN.done;
   wire check_go  = state == ST_CHECK;

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         tr_mode <= TRACE_OFF;
      // Mode sampled as each instruction starts
      end else if (INSN_START) begin
         tr_mode <= SR_TRACE;
      // Skipped or aborted work owes no trace
      end else if (INSN_CANCEL || INSN.done) begin
         tr_mode <= TRACE_OFF;
      end
   end

   // Each completion that meets the trace mode owes a trace
   // Abort cancels; restart resamples and traces later
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         trace_pend <= 1'b0;
      end else begin
         trace_pend <= trace_hit || (trace_pend && !trace_ack);
      end
   end

   // Halt traced in every-instruction mode keeps running after its trace
   wire next_halt_inh = (INSN.done && INSN.halt && tr_mode[1] && !tr_mode[0])
                        || (HALT_INHIBIT && !trace_ack);

   // Boundary arbitration: trace, then interrupt, then breakpoint
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (INSN.done) begin
               // Forced exception runs before its trace
               next_state = INSN.forced ? ST_FORCED : ST_CHECK;
            end else if (EXC_END) begin
               next_state = ST_CHECK;
            end
         end
         ST_FORCED: begin
            if (EXC_END) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            // Trace first, interrupt waits a pass
            // Breakpoint only when nothing else owed
            if (trace_pend) begin
               next_state = ST_EXC;
            end else if (int_level != LEVEL_NONE) begin
               next_state = ST_IACK;
            end else if (BKPT_PEND) begin
               next_state = ST_EXC;
            end else begin
               next_state = ST_RUN;
            end
         end
         ST_EXC: begin
            if (EXC_END) begin
               next_state = ST_CHECK;
            end
         end
         ST_IACK: begin
            if (IACK_DONE) begin
               next_state = ST_EXC;
            end
         end
      endcase
   end

   wire [7:0] irq_vec = IACK_BERR    ? VEC_SPURIOUS :
                        IACK_AUTOVEC ? VEC_AUTO_BASE + {5'h00, iack_lvl} :
                                       IACK_DATA;

   // Checked before any interrupt, so trace is visible first
   wire       take_trace = check_go && trace_pend;
   wire       take_irq   = check_go && !trace_pend && int_level != LEVEL_NONE;
   wire       take_bkpt  = check_go && !trace_pend && int_level == LEVEL_NONE && BKPT_PEND;
   wire       irq_vec_in = state == ST_IACK && IACK_DONE;

   // Trace request: supervisor, trace bits cleared
   // Interrupt request: mask set to its level
   // Vector chosen here; core stacks and jumps
   tiu_exc_t next_exc;
   always_comb begin
      next_exc = EXC;
      if (take_trace) begin
         next_exc = '{1'b1, EK_TRACE, VEC_TRACE, SR_MASK, 1'b1, 1'b1};
      end else if (take_bkpt) begin
         next_exc = '{1'b1, EK_BKPT, VEC_BKPT, SR_MASK, 1'b1, 1'b1};
      end else if (irq_vec_in) begin
         next_exc = '{1'b1, EK_IRQ, irq_vec, iack_lvl, 1'b1, 1'b1};
      end else if (state == ST_EXC && EXC_END) begin
         next_exc.valid = 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         state <= ST_RUN;
         EXC   <= '{1'b0, EK_TRACE, 8'h00, 3'h0, 1'b0, 1'b0};
      end else begin
         state <= next_state;
         EXC   <= next_exc;
      end
   end

   // Acknowledge in special space, level on address
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         iack_lvl   <= LEVEL_NONE;
         IACK_REQ   <= 1'b0;
         IACK_ADDR  <= LEVEL_NONE;
         IACK_SPACE <= 4'h0;
      end else if (take_irq) begin
         iack_lvl   <= int_level;
         IACK_REQ   <= 1'b1;
         IACK_ADDR  <= int_level;
         IACK_SPACE <= IACK_SPACE_CODE;
      end else if (irq_vec_in) begin
         IACK_REQ   <= 1'b0;
         IACK_SPACE <= 4'h0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         PROCEED       <= 1'b0;
         HALT_INHIBIT  <= 1'b0;
         TRACE_PENDING <= 1'b0;
         IPEND_LEVEL   <= LEVEL_NONE;
      end else begin
         PROCEED       <= check_go && next_state == ST_RUN;
         HALT_INHIBIT  <= next_halt_inh;
         TRACE_PENDING <= trace_hit || (trace_pend && !trace_ack);
         IPEND_LEVEL   <= int_level;
      end
   end

   default clocking tiu_cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);

   chk_trace_before_irq: assert property (
      (state == ST_CHECK && trace_pend) |=> !IACK_REQ && EXC.kind == EK_TRACE
   ) else $error("interrupt taken ahead of owed trace");

   chk_irq_masked: assert property (
      $rose(IACK_REQ) |-> (IACK_ADDR == LEVEL_NMI || IACK_ADDR > $past(SR_MASK))
   ) else $error("masked level acknowledged");

   chk_filter_stable: assert property (
      $changed(irq_filt) |-> $past(irq_s2, 1) == $past(irq_s2, 2)
   ) else $error("request accepted before two stable periods");

   chk_nmi_latch: assert property (
      (nmi_pend && !nmi_ack) |=> nmi_pend
   ) else $error("level seven pending lost before acknowledge");

   chk_iack_space: assert property (
      IACK_REQ |-> IACK_SPACE == IACK_SPACE_CODE && IACK_ADDR != LEVEL_NONE
   ) else $error("acknowledge outside special space");

   chk_autovector: assert property (
      (IACK_REQ && IACK_DONE && IACK_AUTOVEC && !IACK_BERR)
      |=> EXC.valid && EXC.vector == VEC_AUTO_BASE + {5'h00, $past(IACK_ADDR)}
   ) else $error("autovector not built from level");

   chk_spurious_vec: assert property (
      (IACK_REQ && IACK_DONE && IACK_BERR) |=> EXC.vector == VEC_SPURIOUS
   ) else $error("bus error answer not spurious");

   chk_irq_entry: assert property (
      (EXC.valid && EXC.kind == EK_IRQ) |-> EXC.new_mask == iack_lvl && EXC.set_super && EXC.clr_trace
   ) else $error("interrupt entry state wrong");

   chk_rte_untraced: assert property (
      (INSN.done && INSN.rte_fault && !trace_pend) |=> !trace_pend
   ) else $error("fault return traced");

   chk_reserved_mode: assert property (
      (INSN.done && tr_mode == TRACE_RSVD && !trace_pend) |=> !trace_pend
   ) else $error("reserved trace mode traced");

endmodule

// File: dv/tiu_responder.sv
// Interrupting peripheral and acknowledge responder model
`timescale 1ns/1ps
module tiu_responder
   import tiu_pkg::*;
(
   input  wire logic       clock,    // Core clock
   input  wire logic       reset_n,  // Sync reset
   input  wire logic       req,      // Acknowledge cycle requested
   input  wire logic [2:0] level,    // Level on address bus
   input  wire logic [1:0] mode,     // 0 vector, 1 auto, 2 error, 3 fresh
   input  wire logic [2:0] delay,    // Wait states
   output logic            done,     // Cycle ends
   output logic            autovec,  // Ask for autovector
   output logic            berr,     // End by bus error
   output logic [7:0]      data      // Vector byte
);
   logic [2:0] cnt;
   logic       answered;
   logic [7:0] vec;

   assign vec     = (mode == 2'h3) ? 8'h0f : (8'h40 | {5'h00, level});
   // Released bus shows the inverse, never a usable vector
   assign data    = done ? vec : ~vec;
   assign autovec = done && mode == 2'h1;
   assign berr    = done && mode == 2'h2;

   always_ff @(posedge clock) begin
      if (!reset_n || !req) begin
         cnt      <= 3'h0;
         answered <= 1'b0;
         done     <= 1'b0;
      end else if (!answered && cnt == delay) begin
         done     <= 1'b1;
         answered <= 1'b1;
      end else begin
         cnt      <= cnt + 3'h1;
         done     <= 1'b0;
      end
   end
endmodule

// File: dv/tiu_unit_test.sv
// Self-checking bench for the trace and interrupt exception unit
`timescale 1ns/1ps
module tiu_unit_test
   import tiu_pkg::*;
;
   logic       clock, reset_n, insn_start, insn_cancel, exc_end, bkpt_pend;
   logic       iack_done, iack_autovec, iack_berr, iack_req, proceed, halt_inhibit, trace_pending;
   logic [7:1] irq_n;
   logic [1:0] sr_trace, rmode;
   logic [2:0] sr_mask, iack_addr, ipend_level, rdelay, exp_lvl, lvl;
   logic [3:0] iack_space;
   logic [7:0] iack_data, vec;
   logic [31:0] r;
   tiu_insn_t  insn;
   tiu_exc_t   exc, e;
   tiu_exc_t   expq[$];
   logic       taken;
   int         n_errors, checked, cycles, i;
   int         seed = 32'h710f;

   tiu_unit DUT (.CLOCK(clock), .RESET_N(reset_n), .IRQ_N(irq_n), .SR_TRACE(sr_trace), .SR_MASK(sr_mask),
      .INSN_START(insn_start), .INSN(insn), .INSN_CANCEL(insn_cancel), .EXC_END(exc_end), .BKPT_PEND(bkpt_pend),
      .IACK_DONE(iack_done), .IACK_AUTOVEC(iack_autovec), .IACK_BERR(iack_berr), .IACK_DATA(iack_data),
      .EXC(exc), .IACK_REQ(iack_req), .IACK_SPACE(iack_space), .IACK_ADDR(iack_addr), .PROCEED(proceed),
      .HALT_INHIBIT(halt_inhibit), .TRACE_PENDING(trace_pending), .IPEND_LEVEL(ipend_level));

   tiu_responder resp (.clock(clock), .reset_n(reset_n), .req(iack_req), .level(iack_addr), .mode(rmode),
      .delay(rdelay), .done(iack_done), .autovec(iack_autovec), .berr(iack_berr), .data(iack_data));

   task automatic final_report();
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic tiu_insn_t mk(input logic n, input logic f, input logic h, input logic x);
      return {1'b1, n, f, h, x};
   endfunction

   task automatic end_exc();
      @(negedge clock);
      exc_end = 1'b1;
      @(negedge clock);
      exc_end = 1'b0;
   endtask

   task automatic run(input logic [1:0] m, input tiu_insn_t q, input logic cancel, input logic irq);
      logic tr;
      int   k;
      tr = !cancel && !q.rte_fault && (m == TRACE_EACH || (m == TRACE_FLOW && q.nonseq));
      if (tr) expq.push_back(tiu_exc_t'{1'b1, EK_TRACE, VEC_TRACE, 3'h0, 1'b1, 1'b1});
      if (irq) expq.push_back(tiu_exc_t'{1'b1, EK_IRQ, vec, exp_lvl, 1'b1, 1'b1});
      if (bkpt_pend) expq.push_back(tiu_exc_t'{1'b1, EK_BKPT, VEC_BKPT, 3'h0, 1'b1, 1'b1});
      sr_trace = m;
      insn_start = 1'b1;
      @(negedge clock);
      insn_start = 1'b0;
      @(negedge clock);
      if (cancel) insn_cancel = 1'b1;
      else insn = q;
      @(negedge clock);
      insn = '0;
      insn_cancel = 1'b0;
      // Untraced work pulses proceed at the next edge, so look now
      chk("halt inhibit", halt_inhibit, q.halt && m == TRACE_EACH && !cancel);
      chk("trace pending", trace_pending, tr);
      if (q.forced || cancel) begin
         chk("early exc", exc.valid, 1'b0);
         end_exc();
      end
      for (k = 0; k < 300 && proceed !== 1'b1; k++) @(negedge clock);
      chk("proceed", k < 300, 1'b1);
      chk("exc left", expq.size(), 0);
   endtask

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         final_report();
      end
   end

   always @(negedge clock) begin
      if (iack_req === 1'b1) begin
         chk("iack space", iack_space, IACK_SPACE_CODE);
         chk("iack level", iack_addr, exp_lvl);
      end
   end

   // Stands in for the core's stacking sequencer
   initial begin
      forever begin
         @(negedge clock);
         if (exc.valid === 1'b1) begin
            e = expq.size() ? expq.pop_front() : '0;
            chk("exc kind", exc.kind, e.kind);
            chk("exc vector", exc.vector, e.vector);
            chk("exc flags", {exc.set_super, exc.clr_trace}, 2'h3);
            if (e.kind == EK_IRQ) begin
               chk("exc mask", exc.new_mask, e.new_mask);
               sr_mask = e.new_mask;
               irq_n = 7'h7f;
            end
            if (e.kind == EK_BKPT) bkpt_pend = 1'b0;
            end_exc();
            repeat (2) @(negedge clock);
         end
      end
   end

   initial begin
      {reset_n, insn_start, insn_cancel, exc_end, bkpt_pend, sr_trace, sr_mask} = '0;
      {insn, rmode, rdelay, exp_lvl, vec} = '0;
      irq_n = 7'h7f;
      repeat (12) @(negedge clock);
      reset_n = 1'b1;
      for (i = 0; i < 8; i++) run(i[2:1], mk(i[0], 1'b0, 1'b0, 1'b0), 1'b0, 1'b0);
      run(TRACE_EACH, mk(1'b0, 1'b0, 1'b0, 1'b0), 1'b1, 1'b0);
      run(TRACE_EACH, mk(1'b0, 1'b0, 1'b0, 1'b0), 1'b0, 1'b0);
      run(TRACE_EACH, mk(1'b1, 1'b0, 1'b0, 1'b1), 1'b0, 1'b0);
      run(TRACE_EACH, mk(1'b0, 1'b1, 1'b0, 1'b0), 1'b0, 1'b0);
      run(TRACE_EACH, mk(1'b0, 1'b0, 1'b1, 1'b0), 1'b0, 1'b0);
      run(TRACE_FLOW, mk(1'b0, 1'b0, 1'b1, 1'b0), 1'b0, 1'b0);
      bkpt_pend = 1'b1;
      run(TRACE_EACH, mk(1'b0, 1'b0, 1'b0, 1'b0), 1'b0, 1'b0);
      irq_n = 7'h3f;
      @(negedge clock);
      irq_n = 7'h7f;
      repeat (6) @(negedge clock);
      chk("glitch", ipend_level, LEVEL_NONE);
      for (i = 0; i < 32; i++) begin
         r = $random(seed);
         lvl = (r[2:0] == 3'h0) ? LEVEL_NMI : r[2:0];
         sr_mask = r[5:3];
         rmode = r[7:6];
         rdelay = r[10:8];
         exp_lvl = lvl;
         taken = lvl == LEVEL_NMI || lvl > r[5:3];
         irq_n = ~(7'h01 << (lvl - 3'h1));
         repeat (8) @(negedge clock);
         chk("pend level", ipend_level, taken ? lvl : LEVEL_NONE);
         vec = (rmode == 2'h2) ? VEC_SPURIOUS : (rmode == 2'h1) ? VEC_AUTO_BASE + lvl :
               (rmode == 2'h3) ? 8'h0f : (8'h40 | {5'h00, lvl});
         run(r[11] ? TRACE_EACH : TRACE_OFF, mk(1'b0, 1'b0, 1'b0, 1'b0), 1'b0, taken);
         irq_n = 7'h7f;
         repeat (6) @(negedge clock);
      end
      final_report();
   end
endmodule
